// [core/dbpc_top.sv]
// drive bay power and update control: slot power, fault indicators,
// fans, private two-wire bus, firmware transfer mode
// assumes one 100 MHz clock; pins are asynchronous, command ports are
// driven by logic on the same clock
//
// Functional notes
// - forced update jumper enters transfer mode; normal jumper runs normal code.
// - boot block writes blocked while boot jumper reads protect.
// - drive-bus failure report switches that slot's power off.
// - new insertion waits a settling delay before power is applied.
// - with system power on, a withdrawn drive loses slot power at once.
// - spare slots stay off until another drive fails, then the lowest ready spare powers up.
// - a shorted drive makes the slot bypass its power-control path.
// - one fault indicator per slot shows that drive's failure status.
// - all fault indicators light together for 1 s during self-test.
// - program store is an 8KB boot region plus 24KB operational region.
// - operational region is writable in transfer mode regardless of jumper.
// - transfer mode entered by management enter command or forced jumper.
// - command-entered transfer mode ends on the exit command.
// - jumper-entered transfer mode ends only on power cycle; exit refused.
// - firmware images arrive only over the management bus.
// - register port switches each of two fan outputs on or off.
// - tach inputs measured; degraded and stalled fans are flagged.
// - private two-wire bus lines driven directly under program control.
// - fault outputs are open-collector, active low, slot 0 first.
`timescale 1ns/100ps
module dbpc_top #(
  parameter int unsigned SETTLE_CYCLES = dbpc_pkg::SETTLE_CYCLES,
  parameter int unsigned SELFTEST_CYCLES = dbpc_pkg::SELFTEST_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [31:0] regRdData,
  input wire logic updateForceJumper,
  input wire logic bootRegionWriteJumper,
  input wire logic systemPowerOn,
  input wire logic [dbpc_pkg::NSLOT-1:0] slotPresent,
  input wire logic [dbpc_pkg::NSLOT-1:0] slotShort,
  input wire logic [dbpc_pkg::NFAN-1:0] fanTach,
  input wire logic esmFailValid,
  input wire logic [dbpc_pkg::SLOT_IDX_W-1:0] esmFailSlot,
  input wire logic mgmtValid,
  input wire dbpc_pkg::dbpc_mgmt_op_t mgmtOp,
  input wire logic [dbpc_pkg::STORE_AW-1:0] mgmtAddr,
  input wire logic [7:0] mgmtData,
  output logic mgmtRefused,
  output logic storeWrEn,
  output logic [dbpc_pkg::STORE_AW-1:0] storeWrAddr,
  output logic [7:0] storeWrData,
  output logic xferMode,
  output logic normalRun,
  output logic [dbpc_pkg::NSLOT-1:0] slotPowerEn,
  output logic [dbpc_pkg::NSLOT-1:0] slotBypass,
  output logic [dbpc_pkg::NSLOT-1:0] slotFaultNOut,
  output logic [dbpc_pkg::NSLOT-1:0] slotFaultNOe,
  output logic [dbpc_pkg::NFAN-1:0] fanPowerEn,
  input wire logic privSclIn,
  output logic privSclOut,
  output logic privSclOe,
  input wire logic privSdaIn,
  output logic privSdaOut,
  output logic privSdaOe
);
  import dbpc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int PIN_W = 17;
  localparam logic [SETTLE_CNT_W-1:0] SETTLE_LOAD = SETTLE_CNT_W'(SETTLE_CYCLES - 1);
  localparam logic [SELFTEST_CNT_W-1:0] SELFTEST_LAST = SELFTEST_CNT_W'(SELFTEST_CYCLES - 1);
  localparam logic [FAN_CNT_W-1:0] FAN_CNT_MAX = '1;

  typedef struct packed {
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    logic [NSLOT-1:0] prevPresent;
    logic [NFAN-1:0] prevTach;
    dbpc_mode_t mode;
    logic [SELFTEST_CNT_W-1:0] stCnt;
    logic selfTest;
    dbpc_slot_t [NSLOT-1:0] slot;
    logic [NSLOT-1:0][SETTLE_CNT_W-1:0] settleCnt;
    logic [NSLOT-1:0] failed;
    logic [NSLOT-1:0] spareActive;
    logic [NSLOT-1:0] bypass;
    logic [NSLOT-1:0] faultLed;
    logic [NSLOT-1:0] spareMask;
    logic [NSLOT-1:0] faultForce;
    logic [NFAN-1:0] fanPower;
    logic [NFAN-1:0][FAN_CNT_W-1:0] fanCnt;
    logic [NFAN-1:0][FAN_CNT_W-1:0] fanPeriod;
    logic [NFAN-1:0] stalled;
    logic [FAN_CNT_W-1:0] fanLimit;
    logic sclLow;
    logic sdaLow;
    logic storeWr;
    logic [STORE_AW-1:0] storeAddr;
    logic [7:0] storeData;
    logic refused;
    logic [31:0] rdData;
  } dbpc_state_t;

  dbpc_state_t q;
  dbpc_state_t d;

  // ----------------------------------------------------------------
  // synchronised pins
  // ----------------------------------------------------------------
  logic updJumperS;
  logic bootWrJumperS;
  logic sysPowerS;
  logic [NSLOT-1:0] presentS;
  logic [NSLOT-1:0] shortS;
  logic [NFAN-1:0] tachS;
  logic sclS;
  logic sdaS;

  assign updJumperS = q.sync2[0];
  assign bootWrJumperS = q.sync2[1];
  assign sysPowerS = q.sync2[2];
  assign presentS = q.sync2[7:3];
  assign shortS = q.sync2[12:8];
  assign tachS = q.sync2[14:13];
  assign sclS = q.sync2[15];
  assign sdaS = q.sync2[16];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic insert;
    logic found;
    logic [NFAN-1:0] degraded;
    logic [SLOT_IDX_W-1:0] failIdx;
    logic failHit;
    insert = 1'b0;
    found = 1'b0;
    degraded = '0;
    failIdx = esmFailSlot;
    failHit = 1'b0;
    d = q;
    d.sync1 = {privSdaIn, privSclIn, fanTach, slotShort, slotPresent,
               systemPowerOn, bootRegionWriteJumper, updateForceJumper};
    d.sync2 = q.sync1;
    d.prevPresent = presentS;
    d.prevTach = tachS;
    d.storeWr = 1'b0;
    d.refused = 1'b0;
    d.rdData = '0;

    if (q.selfTest) begin
      d.stCnt = q.stCnt + 1'b1;
      if (q.stCnt >= SELFTEST_LAST) begin
        d.selfTest = 1'b0;
      end
    end

    // strap caught after release, once the synchroniser has settled
    // jumper selects start mode
    if (q.mode == MODE_BOOT && q.stCnt >= JUMPER_SAMPLE_CYCLE) begin
      if (updJumperS) begin
        d.mode = MODE_XFER_JUMPER;
      end else begin
        d.mode = MODE_NORMAL;
      end
    end

    // ----------------------------------------------------------------
    // management bus commands; drive bus has no image path
    // ----------------------------------------------------------------
    if (mgmtValid) begin
      case (mgmtOp)
        MOP_ENTER: begin
          if (q.mode == MODE_NORMAL) begin
            d.mode = MODE_XFER_CMD;
          end else if (q.mode == MODE_BOOT) begin
            d.refused = 1'b1;
          end
        end
        MOP_EXIT: begin
          if (q.mode == MODE_XFER_CMD) begin
            d.mode = MODE_NORMAL;
          end else begin
            d.refused = 1'b1;
          end
        end
        MOP_IMAGE_WRITE: begin
          if (q.mode != MODE_XFER_CMD && q.mode != MODE_XFER_JUMPER) begin
            d.refused = 1'b1;
          end else if (mgmtAddr < BOOT_REGION_END && !bootWrJumperS) begin
            d.refused = 1'b1;
          end else begin
            d.storeWr = 1'b1;
            d.storeAddr = mgmtAddr;
            d.storeData = mgmtData;
          end
        end
        default: begin
          d.refused = 1'b0;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // slot power
    // ----------------------------------------------------------------
    failHit = esmFailValid && (int'(failIdx) < NSLOT);
    // lowest ready spare takes over a reported failure
    if (failHit && !q.failed[failIdx]) begin
      for (int j = 0; j < NSLOT; j++) begin
        if (!found && q.spareMask[j] && !q.spareActive[j] && presentS[j] &&
            (int'(failIdx) != j)) begin
          d.spareActive[j] = 1'b1;
          found = 1'b1;
        end
      end
    end

    for (int i = 0; i < NSLOT; i++) begin
      insert = presentS[i] && !q.prevPresent[i];
      case (q.slot[i])
        SLOT_OFF: begin
          if (presentS[i] && !q.failed[i] && !q.bypass[i] &&
              (!q.spareMask[i] || q.spareActive[i])) begin
            if (insert) begin
              d.slot[i] = SLOT_SETTLE;
              d.settleCnt[i] = SETTLE_LOAD;
            end else if (q.spareActive[i]) begin
              d.slot[i] = SLOT_ON;
            end
          end
        end
        SLOT_SETTLE: begin
          if (!presentS[i]) begin
            d.slot[i] = SLOT_OFF;
          end else if (q.settleCnt[i] == '0) begin
            d.slot[i] = SLOT_ON;
          end else begin
            d.settleCnt[i] = q.settleCnt[i] - 1'b1;
          end
        end
        SLOT_ON: begin
          if (!presentS[i] && sysPowerS) begin
            d.slot[i] = SLOT_OFF;
          end
        end
        default: begin
          d.slot[i] = SLOT_OFF;
        end
      endcase

      if (failHit && int'(failIdx) == i) begin
        d.failed[i] = 1'b1;
        d.slot[i] = SLOT_OFF;
      end

      // short takes the control path out
      if (shortS[i] && presentS[i]) begin
        d.bypass[i] = 1'b1;
        d.slot[i] = SLOT_OFF;
      end

      // only a removal clears the failure latch
      if (!presentS[i]) begin
        d.failed[i] = 1'b0;
        d.bypass[i] = 1'b0;
        d.spareActive[i] = 1'b0;
      end

      d.faultLed[i] = q.selfTest || d.failed[i] || q.faultForce[i];
    end

    // ----------------------------------------------------------------
    // fan tachometers; a stopped fan saturates the counter
    // ----------------------------------------------------------------
    // period and stall detection
    for (int f = 0; f < NFAN; f++) begin
      if (tachS[f] && !q.prevTach[f]) begin
        d.fanPeriod[f] = q.fanCnt[f];
        d.fanCnt[f] = '0;
        d.stalled[f] = 1'b0;
      end else if (q.fanCnt[f] != FAN_CNT_MAX) begin
        d.fanCnt[f] = q.fanCnt[f] + 1'b1;
      end else begin
        d.stalled[f] = 1'b1;
      end
      degraded[f] = q.fanPeriod[f] > q.fanLimit;
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    if (regWrEn) begin
      if (regAddr == REG_FAN_CTRL) begin
        d.fanPower = regWrData[NFAN-1:0];
      end else if (regAddr == REG_SPARE) begin
        d.spareMask = regWrData[NSLOT-1:0];
      end else if (regAddr == REG_FAULT_FORCE) begin
        d.faultForce = regWrData[NSLOT-1:0];
      end else if (regAddr == REG_FAN_LIMIT) begin
        d.fanLimit = regWrData[FAN_CNT_W-1:0];
      end else if (regAddr == REG_PRIV_BUS) begin
        d.sclLow = regWrData[PRIV_SCL_LOW_BIT];
        d.sdaLow = regWrData[PRIV_SDA_LOW_BIT];
      end
    end

    // ----------------------------------------------------------------
    // register reads, data in the following cycle only
    // ----------------------------------------------------------------
    if (regRdEn) begin
      if (regAddr == REG_FAN_CTRL) begin
        d.rdData[NFAN-1:0] = q.fanPower;
      end else if (regAddr == REG_SPARE) begin
        d.rdData[NSLOT-1:0] = q.spareMask;
      end else if (regAddr == REG_FAULT_FORCE) begin
        d.rdData[NSLOT-1:0] = q.faultForce;
      end else if (regAddr == REG_SLOT_STATUS) begin
        for (int i = 0; i < NSLOT; i++) begin
          d.rdData[STAT_POWER_LSB + i] = (q.slot[i] == SLOT_ON);
        end
        d.rdData[STAT_PRESENT_LSB +: NSLOT] = presentS;
        d.rdData[STAT_FAILED_LSB +: NSLOT] = q.failed;
        d.rdData[STAT_BYPASS_LSB +: NSLOT] = q.bypass;
      end else if (regAddr == REG_MODE_STATUS) begin
        d.rdData[MODE_CODE_LSB +: 2] = q.mode;
        d.rdData[MODE_SELFTEST_BIT] = q.selfTest;
        d.rdData[MODE_BOOTWR_BIT] = bootWrJumperS;
        d.rdData[MODE_SPARE_LSB +: NSLOT] = q.spareActive;
      end else if (regAddr == REG_FAN0_PERIOD) begin
        d.rdData[FAN_CNT_W-1:0] = q.fanPeriod[0];
      end else if (regAddr == REG_FAN1_PERIOD) begin
        d.rdData[FAN_CNT_W-1:0] = q.fanPeriod[1];
      end else if (regAddr == REG_FAN_STATUS) begin
        d.rdData[FANST_DEGRADED_LSB +: NFAN] = degraded;
        d.rdData[FANST_STALLED_LSB +: NFAN] = q.stalled;
      end else if (regAddr == REG_FAN_LIMIT) begin
        d.rdData[FAN_CNT_W-1:0] = q.fanLimit;
      end else if (regAddr == REG_PRIV_BUS) begin
        d.rdData[PRIV_SCL_LOW_BIT] = q.sclLow;
        d.rdData[PRIV_SDA_LOW_BIT] = q.sdaLow;
        d.rdData[PRIV_SCL_IN_BIT] = sclS;
        d.rdData[PRIV_SDA_IN_BIT] = sdaS;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q.sync1 <= '0;
      q.sync2 <= '0;
      q.prevPresent <= '0;
      q.prevTach <= '0;
      q.mode <= MODE_BOOT;
      q.stCnt <= '0;
      q.selfTest <= 1'b1;
      q.slot <= '{default: SLOT_OFF};
      q.settleCnt <= '0;
      q.failed <= '0;
      q.spareActive <= '0;
      q.bypass <= '0;
      q.faultLed <= '0;
      q.spareMask <= SPARE_RST;
      q.faultForce <= FAULT_FORCE_RST;
      q.fanPower <= FAN_CTRL_RST;
      q.fanCnt <= '0;
      q.fanPeriod <= '0;
      q.stalled <= '0;
      q.fanLimit <= FAN_LIMIT_RST;
      q.sclLow <= 1'b0;
      q.sdaLow <= 1'b0;
      q.storeWr <= 1'b0;
      q.storeAddr <= '0;
      q.storeData <= '0;
      q.refused <= 1'b0;
      q.rdData <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign regRdData = q.rdData;
  assign mgmtRefused = q.refused;
  assign storeWrEn = q.storeWr;
  assign storeWrAddr = q.storeAddr;
  assign storeWrData = q.storeData;
  assign xferMode = (q.mode == MODE_XFER_CMD) || (q.mode == MODE_XFER_JUMPER);
  assign normalRun = (q.mode == MODE_NORMAL);
  assign slotBypass = q.bypass;
  assign fanPowerEn = q.fanPower;

  assign slotFaultNOut = '0;
  assign slotFaultNOe = q.faultLed;

  // lines only pulled low, released high
  assign privSclOut = 1'b0;
  assign privSclOe = q.sclLow;
  assign privSdaOut = 1'b0;
  assign privSdaOe = q.sdaLow;

  genvar gi;
  generate
    for (gi = 0; gi < NSLOT; gi++) begin : g_pwr
      assign slotPowerEn[gi] = (q.slot[gi] == SLOT_ON);
    end
  endgenerate

endmodule

// [include/dbpc_pkg.sv]
// drive bay power and update control: shared constants and types
// assumes a single 100 MHz clock; used by the top level and the bench
package dbpc_pkg;

  // ----------------------------------------------------------------
  // sizes and clock
  // ----------------------------------------------------------------
  localparam int NSLOT = 5;
  localparam int NFAN = 2;
  localparam int SLOT_IDX_W = 3;
  localparam int FAN_CNT_W = 24;
  localparam int SETTLE_CNT_W = 24;
  localparam int SELFTEST_CNT_W = 27;
  localparam int CLK_FREQ_HZ = 100_000_000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SETTLE_TIME_MS = 100;
  localparam int SELFTEST_TIME_MS = 1000;
  localparam int SETTLE_CYCLES = (CLK_FREQ_HZ / 1000) * SETTLE_TIME_MS;
  localparam int SELFTEST_CYCLES = (CLK_FREQ_HZ / 1000) * SELFTEST_TIME_MS;
  localparam logic [SELFTEST_CNT_W-1:0] JUMPER_SAMPLE_CYCLE = 27'h0000003;

  // ----------------------------------------------------------------
  // program store layout
  // ----------------------------------------------------------------
  localparam int STORE_AW = 15;
  localparam int BOOT_REGION_BYTES = 8192;
  localparam int OPER_REGION_BYTES = 24576;
  localparam logic [STORE_AW-1:0] BOOT_REGION_END = 15'h2000;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_FAN_CTRL = 8'h00;
  localparam logic [7:0] REG_SPARE = 8'h04;
  localparam logic [7:0] REG_FAULT_FORCE = 8'h08;
  localparam logic [7:0] REG_SLOT_STATUS = 8'h0c;
  localparam logic [7:0] REG_MODE_STATUS = 8'h10;
  localparam logic [7:0] REG_FAN0_PERIOD = 8'h14;
  localparam logic [7:0] REG_FAN1_PERIOD = 8'h18;
  localparam logic [7:0] REG_FAN_STATUS = 8'h1c;
  localparam logic [7:0] REG_FAN_LIMIT = 8'h20;
  localparam logic [7:0] REG_PRIV_BUS = 8'h24;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int STAT_POWER_LSB = 0;
  localparam int STAT_PRESENT_LSB = 8;
  localparam int STAT_FAILED_LSB = 16;
  localparam int STAT_BYPASS_LSB = 24;
  localparam int MODE_CODE_LSB = 0;
  localparam int MODE_SELFTEST_BIT = 4;
  localparam int MODE_BOOTWR_BIT = 5;
  localparam int MODE_SPARE_LSB = 8;
  localparam int FANST_DEGRADED_LSB = 0;
  localparam int FANST_STALLED_LSB = 2;
  localparam int PRIV_SCL_LOW_BIT = 0;
  localparam int PRIV_SDA_LOW_BIT = 1;
  localparam int PRIV_SCL_IN_BIT = 8;
  localparam int PRIV_SDA_IN_BIT = 9;
  localparam logic [NFAN-1:0] FAN_CTRL_RST = 2'h3;
  localparam logic [NSLOT-1:0] SPARE_RST = 5'h00;
  localparam logic [NSLOT-1:0] FAULT_FORCE_RST = 5'h00;
  localparam logic [FAN_CNT_W-1:0] FAN_LIMIT_RST = 24'h0f4240;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MOP_ENTER,
    MOP_EXIT,
    MOP_IMAGE_WRITE,
    MOP_NONE
  } dbpc_mgmt_op_t;

  typedef enum logic [1:0] {
    MODE_BOOT,
    MODE_NORMAL,
    MODE_XFER_CMD,
    MODE_XFER_JUMPER
  } dbpc_mode_t;

  typedef enum logic [1:0] {
    SLOT_OFF,
    SLOT_SETTLE,
    SLOT_ON
  } dbpc_slot_t;

endpackage

// [verif/dbpc_host_model.sv]
// host side model: drive-bus initiator and management controller
// assumes the top's command ports sit on the same clock
`timescale 1ns/100ps
module dbpc_host_model (
  input wire logic clk,
  output logic mgmtValid,
  output dbpc_pkg::dbpc_mgmt_op_t mgmtOp,
  output logic [dbpc_pkg::STORE_AW-1:0] mgmtAddr,
  output logic [7:0] mgmtData,
  output logic esmFailValid,
  output logic [dbpc_pkg::SLOT_IDX_W-1:0] esmFailSlot
);
  import dbpc_pkg::*;
  // ----------------------------------------------------------------
  // one-cycle requests
  // ----------------------------------------------------------------
  initial begin
    mgmtValid = 1'b0;
    mgmtOp = MOP_NONE;
    mgmtAddr = 15'h0000;
    mgmtData = 8'h00;
    esmFailValid = 1'b0;
    esmFailSlot = 3'h0;
  end
  task automatic fail(input logic [SLOT_IDX_W-1:0] s);
    @(posedge clk);
    esmFailValid <= 1'b1;
    esmFailSlot <= s;
    @(posedge clk);
    esmFailValid <= 1'b0;
    esmFailSlot <= ~s;
  endtask
  task automatic mgmt(input dbpc_mgmt_op_t op, input logic [STORE_AW-1:0] a,
                      input logic [7:0] d);
    @(posedge clk);
    mgmtValid <= 1'b1;
    mgmtOp <= op;
    mgmtAddr <= a;
    mgmtData <= d;
    @(posedge clk);
    mgmtValid <= 1'b0;
    mgmtOp <= MOP_NONE;
    // released lines scrambled, not held
    mgmtAddr <= ~a;
    mgmtData <= ~d;
  endtask
endmodule

// [verif/dbpc_monitor.sv]
// checker for dbpc_top port behaviour
// assumes bind onto dbpc_top; one clock, async reset
`timescale 1ns/100ps
module dbpc_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic updateForceJumper,
  input wire logic bootRegionWriteJumper,
  input wire logic systemPowerOn,
  input wire logic [dbpc_pkg::NSLOT-1:0] slotPresent,
  input wire logic [dbpc_pkg::NSLOT-1:0] slotShort,
  input wire logic esmFailValid,
  input wire logic [dbpc_pkg::SLOT_IDX_W-1:0] esmFailSlot,
  input wire logic mgmtValid,
  input wire dbpc_pkg::dbpc_mgmt_op_t mgmtOp,
  input wire logic storeWrEn,
  input wire logic [dbpc_pkg::STORE_AW-1:0] storeWrAddr,
  input wire logic xferMode,
  input wire logic normalRun,
  input wire logic [dbpc_pkg::NSLOT-1:0] slotPowerEn,
  input wire logic [dbpc_pkg::NSLOT-1:0] slotBypass,
  input wire logic [dbpc_pkg::NSLOT-1:0] slotFaultNOe,
  input wire logic [dbpc_pkg::NFAN-1:0] fanPowerEn,
  input wire logic privSclOe,
  input wire logic privSdaOe
);
  import dbpc_pkg::*;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_mode;
    $fell(reset) |-> ##6 xferMode == updateForceJumper && normalRun != updateForceJumper;
  endproperty
  a_mode: assert property (p_mode) else $error("mode vs jumper");
  property p_boot; storeWrEn && storeWrAddr < BOOT_REGION_END |-> bootRegionWriteJumper; endproperty
  a_boot: assert property (p_boot) else $error("boot block written");
  property p_fail;
    esmFailValid && esmFailSlot < 3'h5
      |=> !slotPowerEn[$past(esmFailSlot)] && slotFaultNOe[$past(esmFailSlot)];
  endproperty
  a_fail: assert property (p_fail) else $error("failed slot not off");
  property p_settle; $rose(slotPresent[0]) |=> !slotPowerEn[0] [*8]; endproperty
  a_settle: assert property (p_settle) else $error("no settling");
  property p_pull; systemPowerOn && $fell(slotPresent[0]) |-> ##[1:4] !slotPowerEn[0]; endproperty
  a_pull: assert property (p_pull) else $error("withdrawn slot powered");
  property p_short;
    slotShort[2] && slotPresent[2] |-> ##[1:5] slotBypass[2] && !slotPowerEn[2];
  endproperty
  a_short: assert property (p_short) else $error("short not bypassed");
  property p_lamp; $fell(reset) |=> (slotFaultNOe == 5'h1f) [*8]; endproperty
  a_lamp: assert property (p_lamp) else $error("lamp test missing");
  property p_exit;
    mgmtValid && mgmtOp == MOP_EXIT && xferMode && !updateForceJumper |=> normalRun && !xferMode;
  endproperty
  a_exit: assert property (p_exit) else $error("exit ignored");
  property p_jexit;
    mgmtValid && mgmtOp == MOP_EXIT && updateForceJumper && xferMode |=> xferMode [*4];
  endproperty
  a_jexit: assert property (p_jexit) else $error("jumper mode left");
  property p_store; storeWrEn |-> $past(xferMode); endproperty
  a_store: assert property (p_store) else $error("store write outside transfer");
  property p_fan; regWrEn && regAddr == REG_FAN_CTRL |=> fanPowerEn == $past(regWrData[1:0]); endproperty
  a_fan: assert property (p_fan) else $error("fan power");
  property p_priv;
    regWrEn && regAddr == REG_PRIV_BUS |=> {privSdaOe, privSclOe} == $past(regWrData[1:0]);
  endproperty
  a_priv: assert property (p_priv) else $error("private bus lines");
  c_fail: cover property (esmFailValid ##2 slotPowerEn != 5'h00);
  c_store: cover property (storeWrEn && storeWrAddr < BOOT_REGION_END);
  c_jexit: cover property (mgmtValid && mgmtOp == MOP_EXIT && updateForceJumper);
endmodule

// [verif/tb_dbpc_top.sv]
// self-checking bench for dbpc_top with host model and checker
// assumes dbpc_pkg compiled first; short settle and lamp counts
`timescale 1ns/100ps
module tb_dbpc_top;
  import dbpc_pkg::*;
  localparam int unsigned ST = 20, SF = 50;
  logic clk = 1'b0, reset = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
  logic updateForceJumper = 1'b0, bootRegionWriteJumper = 1'b0, systemPowerOn = 1'b1;
  logic [7:0] regAddr = 8'h00, mgmtData, storeWrData;
  logic [31:0] regWrData = 32'h0, regRdData, r;
  logic [NSLOT-1:0] slotPresent = 5'h0f, slotShort = 5'h00;
  logic [NFAN-1:0] fanTach = 2'h0, fanPowerEn;
  logic esmFailValid, mgmtValid, mgmtRefused, storeWrEn, xferMode, normalRun;
  logic [SLOT_IDX_W-1:0] esmFailSlot;
  dbpc_mgmt_op_t mgmtOp;
  logic [STORE_AW-1:0] mgmtAddr, storeWrAddr;
  logic [NSLOT-1:0] slotPowerEn, slotBypass, slotFaultNOut, slotFaultNOe;
  logic privSclOut, privSclOe, privSdaOut, privSdaOe;
  wire logic privSclIn = !privSclOe, privSdaIn = !privSdaOe;
  int mismatches = 0, samplesChecked = 0, cyc = 0, seed = 77;
  dbpc_top #(.SETTLE_CYCLES(ST), .SELFTEST_CYCLES(SF)) dut_u (.*);
  dbpc_host_model hm (.*);
  always #5 clk = ~clk;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic endSim();
    $display("mismatches=%0d samplesChecked=%0d", mismatches, samplesChecked);
    if (mismatches == 0 && samplesChecked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      mismatches++;
      endSim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [1:0] expImg(input logic [14:0] a, input logic j);
    return (a < BOOT_REGION_END && !j) ? 2'b10 : 2'b01;
  endfunction
  task automatic waitC(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    @(posedge clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1;
    chk(regRdData & m, e);
  endtask
  task automatic cmd(input dbpc_mgmt_op_t op, input logic [14:0] a, input logic [7:0] d,
                     input logic [1:0] e);
    hm.mgmt(op, a, d);
    #1;
    chk({mgmtRefused, storeWrEn}, e);
    if (e == 2'b01) chk({storeWrAddr, storeWrData}, {a, d});
  endtask
  task automatic doReset();
    reset <= 1'b1;
    waitC(4);
    reset <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    doReset();
    waitC(2);
    chk(slotFaultNOe, 5'h1f);
    waitC(SF + 8);
    chk({slotFaultNOe, slotPowerEn}, {5'h00, 5'h0f});
    chk({xferMode, normalRun}, 2'b01);
    rd(REG_FAN_CTRL, 32'h3);
    rd(8'h3c, 32'h0);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      wr(REG_FAN_CTRL, r);
      waitC(1);
      chk(fanPowerEn, r[1:0]);
    end
    wr(REG_PRIV_BUS, 32'h3);
    waitC(4);
    chk({privSdaOe, privSclOe, privSdaOut, privSclOut}, 4'hc);
    rd(REG_PRIV_BUS, 32'h3);
    wr(REG_PRIV_BUS, 32'h0);
    waitC(4);
    rd(REG_PRIV_BUS, 32'h300);
    wr(REG_SPARE, 32'h10);
    slotPresent[4] <= 1'b1;
    waitC(ST + 20);
    chk(slotPowerEn, 5'h0f);
    hm.fail(3'h1);
    waitC(3);
    chk({slotPowerEn, slotFaultNOe, slotFaultNOut}, {5'h1d, 5'h02, 5'h00});
    rd(REG_SLOT_STATUS, 32'h00021f1d);
    hm.fail(3'h1);
    hm.fail(3'h7);
    waitC(3);
    chk(slotPowerEn, 5'h1d);
    slotPresent[1] <= 1'b0;
    waitC(6);
    slotPresent[1] <= 1'b1;
    waitC(ST + 8);
    chk({slotPowerEn, slotFaultNOe}, {5'h1f, 5'h00});
    slotPresent[0] <= 1'b0;
    waitC(5);
    chk(slotPowerEn, 5'h1e);
    slotPresent[0] <= 1'b1;
    waitC(ST / 2);
    slotPresent[0] <= 1'b0;
    waitC(ST + 8);
    chk(slotPowerEn, 5'h1e);
    slotShort[2] <= 1'b1;
    waitC(6);
    chk({slotBypass, slotPowerEn}, {5'h04, 5'h1a});
    slotShort[2] <= 1'b0;
    slotPresent[2] <= 1'b0;
    waitC(6);
    chk(slotBypass, 5'h00);
    cmd(MOP_IMAGE_WRITE, 15'h3000, 8'h5a, 2'b10);
    cmd(MOP_EXIT, 15'h0, 8'h0, 2'b10);
    cmd(MOP_ENTER, 15'h0, 8'h0, 2'b00);
    chk({xferMode, normalRun}, 2'b10);
    cmd(MOP_IMAGE_WRITE, 15'h1fff, 8'ha5, 2'b10);
    cmd(MOP_IMAGE_WRITE, 15'h2000, 8'ha5, 2'b01);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      cmd(MOP_IMAGE_WRITE, r[14:0], r[22:15], expImg(r[14:0], bootRegionWriteJumper));
    end
    bootRegionWriteJumper <= 1'b1;
    waitC(4);
    cmd(MOP_IMAGE_WRITE, 15'h0000, 8'h3c, 2'b01);
    cmd(MOP_EXIT, 15'h0, 8'h0, 2'b00);
    chk({xferMode, normalRun}, 2'b01);
    wr(REG_FAN_LIMIT, 32'h10);
    systemPowerOn <= 1'b0;
    slotPresent[3] <= 1'b0;
    repeat (8) begin
      waitC(20);
      fanTach[0] <= ~fanTach[0];
    end
    chk(slotPowerEn, 5'h1a);
    systemPowerOn <= 1'b1;
    wr(REG_FAULT_FORCE, 32'h5);
    rd(REG_FAN_STATUS, 32'h1, 32'h1);
    chk({slotFaultNOe, slotPowerEn}, {5'h05, 5'h12});
    updateForceJumper <= 1'b1;
    doReset();
    waitC(10);
    chk({xferMode, normalRun}, 2'b10);
    hm.mgmt(MOP_EXIT, 15'h0, 8'h0);
    waitC(2);
    chk(xferMode, 1'b1);
    cmd(MOP_IMAGE_WRITE, 15'h7fff, 8'h81, 2'b01);
    endSim();
  end
endmodule
bind dbpc_top dbpc_monitor mon_u (.*);
